//--- verilog/omc_map.vh
`ifndef OMC_MAP_VH
`define OMC_MAP_VH
// ====================================================================
// byte values
`define OMC_ESC        8'h0F
`define OMC_ESC3_A     8'h38
`define OMC_ESC3_B     8'h3A
`define OMC_PFX_OPSZ   8'h66
`define OMC_PFX_F2     8'hF2
`define OMC_PFX_F3     8'hF3
`define OMC_FAULT_A    8'h0B
`define OMC_FAULT_B    8'hB9
`define OMC_REXPFX_HI  4'h4
`define OMC_MOD_REG    2'h3
`define OMC_MOD_MEM    2'h0
`define OMC_RM_DISP32  3'h5
`define OMC_RM_SIB     3'h4
// ====================================================================
// map selector codes
`define OMC_MAP_ONE    2'h0
`define OMC_MAP_TWO    2'h1
`define OMC_MAP_3A     2'h2
`define OMC_MAP_3B     2'h3
// ====================================================================
// attribute flag positions in the attribute input
`define OMC_F_SPEC     0
`define OMC_F_GRP      1
`define OMC_F_SHARED   2
`define OMC_F_NOLM     3
`define OMC_F_LMONLY   4
`define OMC_F_DEF64    5
`define OMC_F_FRC64    6
`define OMC_F_IMM8     7
`define OMC_ATTR_W     8
// ====================================================================
// operand size codes
`define OMC_OSZ_16     2'h0
`define OMC_OSZ_32     2'h1
`define OMC_OSZ_64     2'h2
// length counters
`define OMC_DISP32_LEN 3'h4
`define OMC_IMM8_LEN   3'h1
`endif

//--- verilog/omc_opcode_map_classifier.v
`timescale 1ns/100ps
// Notes on behaviour
// - 0FH escape selects the two-byte map
// - second byte nibbles give row and column
// - mandatory prefix then 0FH then index byte
// - 0F 38/3A goes to three-byte escape
// - 0F38/0F3A third byte indexes three-byte map
// - prefixed three-byte form, fourth byte indexes
// - three-byte entries always take specifier byte
// - prefixes and no-operand entries take no specifier
// - some entries use specifier reg as extension
// - group entries take bits 5..3 as extension
// - 0F0B and 0FB9 raise invalid opcode fault
// - shared opcodes resolved by specifier byte value
// - not-valid-long-mode entries invalid in 64-bit mode
// - bytes 40..4F are extension prefixes in 64-bit
// - long-mode-only entries valid only in 64-bit
// - default-wide entries use 64-bit size in 64-bit
// - forced-wide entries ignore operand size prefix in 64-bit
// - specifier 05H expects 32-bit displacement; reg 000 accumulator
// - immediate byte follows the displacement bytes
// - specifier C1H is register-direct, reg and r/m vectors
`include "omc_map.vh"

module omc_opcode_map_classifier #(
  parameter ATTR_W = `OMC_ATTR_W
) (
  input  wire              i_core_clk,
  input  wire              i_resetn,
  input  wire              i_byte_valid,
  input  wire [7:0]        i_byte,
  input  wire              i_long_mode,
  input  wire              i_is_prefix,
  input  wire [ATTR_W-1:0] i_attr,
  output wire [1:0]        o_lookup_map,
  output wire [7:0]        o_lookup_index,
  output reg               o_done,
  output reg  [1:0]        o_map,
  output reg  [3:0]        o_row,
  output reg  [3:0]        o_col,
  output reg  [7:0]        o_mandatory_prefix,
  output reg               o_has_spec,
  output reg  [7:0]        o_spec_byte,
  output reg               o_ext_valid,
  output reg  [2:0]        o_ext,
  output reg               o_shared,
  output reg               o_reg_direct,
  output reg  [2:0]        o_spec_reg,
  output reg  [2:0]        o_spec_rm,
  output reg  [3:0]        o_rex,
  output reg  [1:0]        o_opsize,
  output reg               o_fault,
  output reg  [3:0]        o_length,
  output reg  [31:0]       o_disp,
  output reg  [7:0]        o_imm
);

  // ==================================================================
  // states
  localparam [6:0] ST_OP    = 7'h01;
  localparam [6:0] ST_ESC   = 7'h02;
  localparam [6:0] ST_ESC3  = 7'h04;
  localparam [6:0] ST_SPEC  = 7'h08;
  localparam [6:0] ST_DISP  = 7'h10;
  localparam [6:0] ST_IMM   = 7'h20;
  localparam [6:0] ST_FIN   = 7'h40;

  reg [6:0]        state_r;
  reg [1:0]        map_r;
  reg [7:0]        pfx_r;
  reg              opsz_r;
  reg [3:0]        rex_r;
  reg [3:0]        len_r;
  reg [ATTR_W-1:0] attr_r;
  reg [2:0]        disp_cnt_r;
  reg [31:0]       disp_r;
  // staged result, published only with the done pulse
  reg [1:0]        res_map_r;
  reg [3:0]        res_row_r;
  reg [3:0]        res_col_r;
  reg              res_fault_r;
  reg [1:0]        res_osz_r;

  // ==================================================================
  // lookup request: map and index of the byte now presented
  assign o_lookup_map   = (state_r == ST_ESC) ? `OMC_MAP_TWO :
                          (state_r == ST_ESC3) ? map_r : `OMC_MAP_ONE;
  assign o_lookup_index = i_byte;

  wire is_mand = (i_byte == `OMC_PFX_OPSZ) || (i_byte == `OMC_PFX_F2) ||
                 (i_byte == `OMC_PFX_F3);
  wire is_rex  = i_long_mode && (i_byte[7:4] == `OMC_REXPFX_HI);
  wire [1:0] mod_f = i_byte[7:6];
  wire [2:0] rm_f  = i_byte[2:0];
  wire need_disp = (mod_f == `OMC_MOD_MEM) && (rm_f == `OMC_RM_DISP32);

  // attribute-driven validity and size for the current entry
  wire inval_lm = i_long_mode && i_attr[`OMC_F_NOLM];
  wire inval_lo = !i_long_mode && i_attr[`OMC_F_LMONLY];

  function [1:0] size_of;
    input lm;
    input opsz;
    input [ATTR_W-1:0] a;
    begin
      if (lm && (a[`OMC_F_FRC64] || a[`OMC_F_DEF64]))
        size_of = `OMC_OSZ_64;
      else if (opsz)
        size_of = `OMC_OSZ_16;
      else
        size_of = `OMC_OSZ_32;
    end
  endfunction

  // classification of the opcode byte now presented
  wire [1:0] stg_map   = o_lookup_map;
  wire       stg_fault = inval_lm || inval_lo ||
                         ((state_r == ST_ESC) &&
                          ((i_byte == `OMC_FAULT_A) || (i_byte == `OMC_FAULT_B)));
  wire [1:0] stg_osz   = size_of(i_long_mode, opsz_r, i_attr);

  // ==================================================================
  // sequencer
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_r            <= ST_OP;
      map_r              <= `OMC_MAP_ONE;
      pfx_r              <= 8'h00;
      opsz_r             <= 1'b0;
      rex_r              <= 4'h0;
      len_r              <= 4'h0;
      attr_r             <= {ATTR_W{1'b0}};
      disp_cnt_r         <= 3'h0;
      disp_r             <= 32'h0000_0000;
      res_map_r          <= `OMC_MAP_ONE;
      res_row_r          <= 4'h0;
      res_col_r          <= 4'h0;
      res_fault_r        <= 1'b0;
      res_osz_r          <= `OMC_OSZ_32;
      o_done             <= 1'b0;
      o_map              <= `OMC_MAP_ONE;
      o_row              <= 4'h0;
      o_col              <= 4'h0;
      o_mandatory_prefix <= 8'h00;
      o_has_spec         <= 1'b0;
      o_spec_byte        <= 8'h00;
      o_ext_valid        <= 1'b0;
      o_ext              <= 3'h0;
      o_shared           <= 1'b0;
      o_reg_direct       <= 1'b0;
      o_spec_reg         <= 3'h0;
      o_spec_rm          <= 3'h0;
      o_rex              <= 4'h0;
      o_opsize           <= `OMC_OSZ_32;
      o_fault            <= 1'b0;
      o_length           <= 4'h0;
      o_disp             <= 32'h0000_0000;
      o_imm              <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (state_r == ST_FIN) begin
        // one-cycle result pulse already issued; restart
        state_r <= ST_OP;
      end else if (i_byte_valid) begin
        len_r <= len_r + 4'h1;
        case (state_r)
          ST_OP: begin
            if (i_byte == `OMC_ESC) begin
              state_r <= ST_ESC;
            end else if (is_rex) begin
              rex_r <= i_byte[3:0];
            end else if (is_mand && (rex_r == 4'h0)) begin
              if (i_byte == `OMC_PFX_OPSZ)
                opsz_r <= 1'b1;
              else
                pfx_r <= i_byte;
              if (pfx_r == 8'h00 && i_byte == `OMC_PFX_OPSZ)
                pfx_r <= i_byte;
            end else if (i_is_prefix) begin
              rex_r <= 4'h0;
            end else begin
              map_r       <= `OMC_MAP_ONE;
              attr_r      <= i_attr;
              res_map_r   <= stg_map;
              res_row_r   <= i_byte[7:4];
              res_col_r   <= i_byte[3:0];
              res_fault_r <= stg_fault;
              res_osz_r   <= stg_osz;
              state_r  <= i_attr[`OMC_F_SPEC] ? ST_SPEC :
                          (i_attr[`OMC_F_IMM8] ? ST_IMM : ST_FIN);
            end
          end
          ST_ESC: begin
            if (i_byte == `OMC_ESC3_A || i_byte == `OMC_ESC3_B) begin
              map_r   <= (i_byte == `OMC_ESC3_A) ? `OMC_MAP_3A : `OMC_MAP_3B;
              state_r <= ST_ESC3;
            end else begin
              map_r       <= `OMC_MAP_TWO;
              attr_r      <= i_attr;
              res_map_r   <= stg_map;
              res_row_r   <= i_byte[7:4];
              res_col_r   <= i_byte[3:0];
              res_fault_r <= stg_fault;
              res_osz_r   <= stg_osz;
              state_r  <= i_attr[`OMC_F_SPEC] ? ST_SPEC :
                          (i_attr[`OMC_F_IMM8] ? ST_IMM : ST_FIN);
            end
          end
          ST_ESC3: begin
            attr_r      <= i_attr;
            res_map_r   <= stg_map;
            res_row_r   <= i_byte[7:4];
            res_col_r   <= i_byte[3:0];
            res_fault_r <= stg_fault;
            res_osz_r   <= stg_osz;
            state_r  <= ST_SPEC;
          end
          ST_SPEC: begin
            o_has_spec   <= 1'b1;
            o_spec_byte  <= i_byte;
            o_spec_reg   <= i_byte[5:3];
            o_spec_rm    <= rm_f;
            o_reg_direct <= (mod_f == `OMC_MOD_REG);
            o_ext_valid  <= attr_r[`OMC_F_GRP];
            o_ext        <= i_byte[5:3];
            o_shared     <= attr_r[`OMC_F_SHARED];
            disp_cnt_r   <= `OMC_DISP32_LEN;
            if (need_disp)
              state_r <= ST_DISP;
            else if (attr_r[`OMC_F_IMM8])
              state_r <= ST_IMM;
            else
              state_r <= ST_FIN;
          end
          ST_DISP: begin
            // little-endian gathering of the 32-bit displacement
            disp_r     <= {i_byte, disp_r[31:8]};
            disp_cnt_r <= disp_cnt_r - 3'h1;
            if (disp_cnt_r == 3'h1)
              state_r <= attr_r[`OMC_F_IMM8] ? ST_IMM : ST_FIN;
          end
          ST_IMM: begin
            o_imm   <= i_byte;
            state_r <= ST_FIN;
          end
          default: begin
            state_r <= ST_OP;
          end
        endcase
      end
      // publish the instruction on entry to the final state
      if (state_r != ST_FIN && i_byte_valid) begin
        if ((state_r == ST_IMM) ||
            (state_r == ST_DISP && disp_cnt_r == 3'h1 && !attr_r[`OMC_F_IMM8]) ||
            (state_r == ST_SPEC && !need_disp && !attr_r[`OMC_F_IMM8]) ||
            ((state_r == ST_OP) && !(i_byte == `OMC_ESC) && !is_rex &&
             !(is_mand && rex_r == 4'h0) && !i_is_prefix &&
             !i_attr[`OMC_F_SPEC] && !i_attr[`OMC_F_IMM8]) ||
            ((state_r == ST_ESC) && !(i_byte == `OMC_ESC3_A) &&
             !(i_byte == `OMC_ESC3_B) && !i_attr[`OMC_F_SPEC] &&
             !i_attr[`OMC_F_IMM8])) begin
          o_done             <= 1'b1;
          o_length           <= len_r + 4'h1;
          o_mandatory_prefix <= pfx_r;
          o_rex              <= rex_r;
          o_disp             <= (state_r == ST_DISP) ? {i_byte, disp_r[31:8]} : disp_r;
          if (state_r == ST_OP || state_r == ST_ESC) begin
            // opcode byte ends the instruction: publish directly
            o_map       <= stg_map;
            o_row       <= i_byte[7:4];
            o_col       <= i_byte[3:0];
            o_fault     <= stg_fault;
            o_opsize    <= stg_osz;
            o_has_spec  <= 1'b0;
            o_ext_valid <= 1'b0;
            o_shared    <= 1'b0;
          end else begin
            o_map    <= res_map_r;
            o_row    <= res_row_r;
            o_col    <= res_col_r;
            o_fault  <= res_fault_r;
            o_opsize <= res_osz_r;
          end
        end
      end
      // clear per-instruction context once the result is out
      if (state_r == ST_FIN) begin
        pfx_r  <= 8'h00;
        opsz_r <= 1'b0;
        rex_r  <= 4'h0;
        len_r  <= 4'h0;
        disp_r <= 32'h0000_0000;
      end
    end
  end

endmodule // omc_opcode_map_classifier

//--- verif/omc_checker.sv
`timescale 1ns/100ps
`include "omc_map.vh"
// ====================================================================
// port-level checks of the classifier
module omc_checker (
  input wire       i_core_clk,
  input wire       i_resetn,
  input wire       i_byte_valid,
  input wire       o_done,
  input wire [1:0] o_map,
  input wire [3:0] o_row,
  input wire [3:0] o_col,
  input wire [3:0] o_length,
  input wire [7:0] o_mandatory_prefix,
  input wire [7:0] o_spec_byte,
  input wire       o_has_spec,
  input wire       o_ext_valid,
  input wire       o_reg_direct,
  input wire       o_fault,
  input wire [2:0] o_ext,
  input wire [2:0] o_spec_reg,
  input wire [2:0] o_spec_rm,
  input wire [1:0] o_opsize
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // done is a single-cycle pulse
  sequence s_pulse;
    o_done ##1 !o_done;
  endsequence
  AST_DONE_PULSE: assert property (o_done |-> s_pulse)
    else $error("done pulse too long");
  AST_DONE_CAUSE: assert property (o_done |-> $past(i_byte_valid))
    else $error("done without a taken byte");
  AST_HOLD: assert property (!o_done |->
    $stable(o_map) && $stable(o_length) && $stable(o_fault) && $stable(o_opsize))
    else $error("result changed without done");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) !i_resetn |=> !o_done && !o_fault
    && o_length == 4'h0 && o_opsize == `OMC_OSZ_32)
    else $error("reset did not clear results");
  AST_EXT_FIELD: assert property (o_done && o_ext_valid |-> o_ext == o_spec_byte[5:3])
    else $error("extension field wrong");
  AST_SPEC_FIELDS: assert property (o_done && o_has_spec |-> o_spec_reg == o_spec_byte[5:3]
    && o_spec_rm == o_spec_byte[2:0] && o_reg_direct == (o_spec_byte[7:6] == `OMC_MOD_REG))
    else $error("specifier fields wrong");
  AST_THREE_SPEC: assert property (o_done && o_map[1] |-> o_has_spec && o_length >= 4'h4)
    else $error("three-byte entry without specifier");
  AST_FAULT_CODE: assert property (o_done && o_map == `OMC_MAP_TWO && ({o_row, o_col} ==
    `OMC_FAULT_A || {o_row, o_col} == `OMC_FAULT_B) |-> o_fault)
    else $error("fault opcode not flagged");
  AST_DISP_LEN: assert property (o_done && o_has_spec && o_spec_byte == 8'h05 |-> o_length >= 4'h6)
    else $error("displacement not consumed");
  AST_TWO_LEN: assert property (o_done && o_map == `OMC_MAP_TWO |-> o_length >= 4'h2)
    else $error("two-byte opcode too short");
  AST_MAND: assert property (o_done |-> o_mandatory_prefix inside {8'h00, `OMC_PFX_OPSZ,
    `OMC_PFX_F2, `OMC_PFX_F3})
    else $error("bad mandatory prefix");
endmodule // omc_checker

bind omc_opcode_map_classifier omc_checker chk_u (.*);

//--- verif/omc_fetch_model.sv
`timescale 1ns/100ps
// ====================================================================
// fetch side: one byte per valid cycle
module omc_fetch_model (
  input  wire       i_core_clk,
  output reg        o_byte_valid,
  output reg  [7:0] o_byte
);
  initial begin
    o_byte_valid = 1'b0;
    o_byte = 8'hA5;
  end
  // byte launched just after the edge
  task send(input [7:0] b);
    begin
      @(posedge i_core_clk);
      o_byte_valid <= 1'b1;
      o_byte <= b;
    end
  endtask
  // released bus shows inverted data, not a stale byte
  task idle;
    begin
      @(posedge i_core_clk);
      o_byte_valid <= 1'b0;
      o_byte <= ~o_byte;
    end
  endtask
endmodule // omc_fetch_model

//--- verif/omc_opcode_map_classifier_tb.sv
`timescale 1ns/100ps
`include "omc_map.vh"
`define CHK(n, e, g) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
  fails = fails + 1; $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
// ====================================================================
module omc_opcode_map_classifier_tb;
  reg         i_core_clk, i_resetn, i_long_mode;
  wire        i_byte_valid, i_is_prefix, o_done, o_has_spec, o_ext_valid, o_shared;
  wire        o_reg_direct, o_fault;
  wire [7:0]  i_byte, i_attr, o_lookup_index, o_mandatory_prefix, o_spec_byte, o_imm;
  wire [1:0]  o_lookup_map, o_map, o_opsize;
  wire [3:0]  o_row, o_col, o_rex, o_length;
  wire [2:0]  o_ext, o_spec_reg, o_spec_rm;
  wire [31:0] o_disp;
  integer     fails, comparisons, cyc, k, j;
  reg [15:0]  rnd;
  reg [7:0]   q[$];
  reg [7:0]   idx, sp, pf;

  omc_opcode_map_classifier dut_u (.*);
  omc_fetch_model fetch_u (.i_core_clk(i_core_clk), .o_byte_valid(i_byte_valid), .o_byte(i_byte));

  // entry attribute lookup
  function [7:0] attr_of(input [1:0] m, input [7:0] x);
    case ({m, x})
      {`OMC_MAP_ONE, 8'h03}: attr_of = 8'h01;
      {`OMC_MAP_ONE, 8'h80}: attr_of = 8'h83;
      {`OMC_MAP_ONE, 8'h06}: attr_of = 8'h08;
      {`OMC_MAP_ONE, 8'h63}: attr_of = 8'h11;
      {`OMC_MAP_ONE, 8'h50}: attr_of = 8'h20;
      {`OMC_MAP_ONE, 8'hE8}: attr_of = 8'h40;
      {`OMC_MAP_TWO, 8'h0B}: attr_of = 8'h00;
      {`OMC_MAP_TWO, 8'hAE}: attr_of = 8'h05;
      {`OMC_MAP_TWO, 8'hA4}: attr_of = 8'h81;
      {`OMC_MAP_3B, 8'h0F}:  attr_of = 8'h80;
      default:               attr_of = (m == `OMC_MAP_TWO) ? 8'h01 : 8'h00;
    endcase
  endfunction
  assign i_attr = attr_of(o_lookup_map, o_lookup_index);
  assign i_is_prefix = (o_lookup_map == `OMC_MAP_ONE) && (o_lookup_index == 8'h2E);

  // lfsr random source
  function [7:0] nxt;
    begin
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      nxt = rnd[7:0];
    end
  endfunction

  // send queued bytes and wait for done
  task run(input lm);
    integer n;
    begin
      @(posedge i_core_clk);
      i_long_mode <= lm;
      foreach (q[i]) fetch_u.send(q[i]);
      fetch_u.idle();
      n = 0;
      @(negedge i_core_clk);
      while (o_done !== 1'b1 && n < 20) begin
        @(negedge i_core_clk);
        n = n + 1;
      end
      `CHK("done", 1'b1, o_done)
      q.delete();
    end
  endtask

  task core(input [1:0] m, input [7:0] ix, input [3:0] ln, input hs, input ft);
    begin
      `CHK("map", m, o_map)
      `CHK("row", ix[7:4], o_row)
      `CHK("col", ix[3:0], o_col)
      `CHK("length", ln, o_length)
      `CHK("has_spec", hs, o_has_spec)
      `CHK("fault", ft, o_fault)
    end
  endtask

  task give_verdict;
    begin
      if (fails == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // clock and hang guard
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial cyc = 0;
  always @(posedge i_core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      give_verdict;
    end
  end

  // ==================================================================
  // main sequence
  initial begin
    i_resetn = 1'b0;
    i_long_mode = 1'b0;
    fails = 0;
    comparisons = 0;
    rnd = 16'h0003;
    repeat (10) @(posedge i_core_clk);
    @(negedge i_core_clk);
    `CHK("rst_opsize", `OMC_OSZ_32, o_opsize)
    @(posedge i_core_clk);
    i_resetn <= 1'b1;
    // memory operand with displacement, lsb first; then prefixed 0F3A register-direct form
    idx = nxt();
    sp = nxt();
    q = '{8'h03, 8'h05, idx, sp, 8'h5A, 8'hC3};
    run(1'b0);
    core(`OMC_MAP_ONE, 8'h03, 4'h6, 1'b1, 1'b0);
    `CHK("disp", {8'hC3, 8'h5A, sp, idx}, o_disp)
    `CHK("spec_reg", 3'h0, o_spec_reg)
    q = '{8'h0F, 8'hA4, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    run(1'b0);
    core(`OMC_MAP_TWO, 8'hA4, 4'h8, 1'b1, 1'b0);
    `CHK("imm", 8'h03, o_imm)
    q = '{8'h66, 8'h0F, 8'h3A, 8'h0F, 8'hC1, 8'h08};
    run(1'b0);
    core(`OMC_MAP_3B, 8'h0F, 4'h6, 1'b1, 1'b0);
    `CHK("mand", 8'h66, o_mandatory_prefix)
    `CHK("direct", 1'b1, o_reg_direct)
    `CHK("rm", 3'h1, o_spec_rm)
    `CHK("imm", 8'h08, o_imm)
    // every mandatory prefix on two-byte and 0F38 forms
    for (k = 0; k < 4; k = k + 1) begin
      pf = (k == 0) ? 8'h00 : (k == 1) ? 8'h66 : (k == 2) ? 8'hF2 : 8'hF3;
      idx = nxt();
      for (j = 0; j < 2; j = j + 1) begin
        if (pf != 8'h00) q.push_back(pf);
        q.push_back(8'h0F);
        if (j == 1) q.push_back(8'h38);
        q.push_back(j ? idx : 8'h10);
        q.push_back(8'hC1);
        run(1'b0);
        core(j ? `OMC_MAP_3A : `OMC_MAP_TWO, j ? idx : 8'h10, 3 + j + (pf != 0), 1'b1, 1'b0);
        `CHK("mand", pf, o_mandatory_prefix)
      end
    end
    // deliberate fault encodings
    q = '{8'h0F, 8'h0B};
    run(1'b0);
    core(`OMC_MAP_TWO, 8'h0B, 4'h2, 1'b0, 1'b1);
    q = '{8'h0F, 8'hB9, 8'hC0};
    run(1'b1);
    core(`OMC_MAP_TWO, 8'hB9, 4'h3, 1'b1, 1'b1);
    // random two-byte opcodes, register-direct specifier
    repeat (8) begin
      idx = nxt();
      if (idx == 8'h38 || idx == 8'h3A || idx == 8'h0B || idx == 8'hB9 || idx == 8'hAE) idx = 8'h10;
      if (idx == 8'hA4) idx = 8'h10;
      sp = nxt() | 8'hC0;
      q = '{8'h0F, idx, sp};
      run(rnd[15]);
      core(`OMC_MAP_TWO, idx, 4'h3, 1'b1, 1'b0);
      `CHK("spec", sp, o_spec_byte)
    end
    // group entry with immediate, then shared 0FAE entry
    sp = nxt() | 8'hC0;
    q = '{8'h80, sp, 8'h7E};
    run(1'b0);
    core(`OMC_MAP_ONE, 8'h80, 4'h3, 1'b1, 1'b0);
    `CHK("ext_valid", 1'b1, o_ext_valid)
    `CHK("ext", sp[5:3], o_ext)
    q = '{8'h0F, 8'hAE, 8'hF8};
    run(1'b0);
    `CHK("shared", 1'b1, o_shared)
    // extension prefix only in long mode, then mode validity, operand size and 2EH prefix
    q = '{8'h48, 8'h03, 8'hC8};
    run(1'b1);
    core(`OMC_MAP_ONE, 8'h03, 4'h3, 1'b1, 1'b0);
    `CHK("rex", 4'h8, o_rex)
    q = '{8'h48};
    run(1'b0);
    core(`OMC_MAP_ONE, 8'h48, 4'h1, 1'b0, 1'b0);
    for (k = 0; k < 2; k = k + 1) begin
      q = '{8'h06};
      run(k);
      core(`OMC_MAP_ONE, 8'h06, 4'h1, 1'b0, k);
      q = '{8'h63, 8'hC0};
      run(k);
      `CHK("lmonly", !k, o_fault)
    end
    q = '{8'h50};
    run(1'b1);
    `CHK("opsize", `OMC_OSZ_64, o_opsize)
    q = '{8'h66, 8'hE8};
    run(1'b1);
    `CHK("opsize", `OMC_OSZ_64, o_opsize)
    q = '{8'h2E, 8'h03, 8'hC0};
    run(1'b0);
    core(`OMC_MAP_ONE, 8'h03, 4'h3, 1'b1, 1'b0);
    give_verdict;
  end
endmodule // omc_opcode_map_classifier_tb
